/* File: verilog/eesc_port.sv */
// Serial command port and 256x8 data store of the on-chip EEPROM.
// Assumes the core reaches the control register through the indirect pointer.
//
// How it works
// [RULE_01] Fill-all frame: start, 00, 01, 7 spare, byte
// [RULE_02] Fill-all writes every location when the write cycle ends
// [RULE_03] Fill-all needs no prior erase
// [RULE_04] Writes and erases need earlier program unlock
// [RULE_05] Erase frame: start, 11, dummy, address
// [RULE_06] Erase sets addressed byte to all ones
// [RULE_07] Write cycle is self-timed, no serial clock
// [RULE_08] Instructions ignored while write cycle runs
// [RULE_09] Select fall starts cycle; data-out shows busy
// [RULE_10] Controller polls data-out high after select pulse
// [RULE_11] Power-on: unlock, dummy write, optional lock
// [RULE_12] Final lock may be skipped before user writes
// [RULE_13] Control register at 0x40, indirect access only
// [RULE_14] Bits 4..7: select, clock, data-in, data-out
// [RULE_15] Address and data eight bits, MSB first
// [RULE_16] Unlock 00-11, lock 00-00; read unaffected
// [RULE_17] Read: dummy zero, then bytes, address increments
// [RULE_18] Write opcode 01, read opcode 10, dummy first
// [RULE_19] Data-out floats until a read executes
// [RULE_20] Select fall mid-frame discards the frame
// [RULE_21] Data-in sampled on serial clock rising edge
`timescale 1ns/1ps
module eesc_port import eesc_pkg::*; #(
    parameter int unsigned WRITE_LEN = WRITE_CYCLES
) (
    input wire logic clk,                  // System clock, 100 MHz
    input wire logic rst_n,                // Async reset, active low
    input wire logic [7:0] indirect_pointer, // Indirect pointer contents
    input wire logic iap_wr,               // Write strobe on indirect access port
    input wire logic [7:0] iap_wdata,      // Write data on indirect access port
    output logic [7:0] iap_rdata,          // Read data of indirect access port
    output logic serial_out,               // Data-out line level
    output logic serial_out_oe_n           // Data-out enable, low while driven
);
    typedef struct packed {
        logic [2:0] ctrl;          // Select, clock, data-in as written
        logic cs_d;
        logic sk_d;
        eesc_state_t st;
        logic [3:0] cnt;
        logic [1:0] op;
        logic [8:0] sr;
        logic [7:0] addr;
        logic [7:0] data;
        logic [2:0] rd_cnt;
        eesc_job_t job;
        logic unlocked;
        logic do_val;
        logic do_drv;
        logic [7:0] rdata;
        logic [MEM_DEPTH-1:0][7:0] mem;
    } eesc_port_st_t;

    eesc_port_st_t state;
    eesc_port_st_t next_state;
    logic [2:0] line_s;
    logic cs_s;
    logic sk_s;
    logic di_s;
    logic sk_rise;
    logic cs_fall;
    logic cs_rise;
    logic tmr_start;
    logic tmr_busy;
    logic tmr_done;
    logic reg_hit;
    logic do_line;

    // Register lines cross to the serial engine through two flops
    eesc_sync #(.W(3)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(state.ctrl),
        .q(line_s)
    );

    eesc_write_timer #(.CYCLES(WRITE_LEN)) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .start(tmr_start),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    // Edge detection on the synchronised lines
    assign cs_s = line_s[0];
    assign sk_s = line_s[1];
    assign di_s = line_s[2];
    assign sk_rise = sk_s && !state.sk_d;        // see [RULE_21]
    assign cs_fall = !cs_s && state.cs_d;
    assign cs_rise = cs_s && !state.cs_d;
    assign reg_hit = (indirect_pointer == CTRL_ADDR); // see [RULE_13]
    assign do_line = state.do_drv ? state.do_val : 1'b1;
    assign tmr_start = (state.st == ST_DONE) && cs_fall && state.unlocked
        && (state.job != JOB_NONE);

    // Register access, frame parsing, read-out and write commit
    always_comb begin
        next_state = state;
        next_state.cs_d = cs_s;
        next_state.sk_d = sk_s;
        if (iap_wr && reg_hit) begin
            next_state.ctrl = {iap_wdata[DI_BIT], iap_wdata[SK_BIT], iap_wdata[CS_BIT]}; // see [RULE_14]
        end
        next_state.rdata = {do_line, state.ctrl[2], state.ctrl[1], state.ctrl[0], LOW_NIBBLE};
        if (!reg_hit) begin
            next_state.rdata = '0;
        end
        case (state.st)
            ST_IDLE, ST_READY: begin
                if (state.st == ST_READY) begin
                    next_state.do_drv = cs_s;            // see [RULE_09]
                    next_state.do_val = 1'b1;
                end
                if (cs_s && sk_rise && di_s) begin
                    next_state.st = ST_OP;
                    next_state.cnt = '0;
                    next_state.do_drv = 1'b0;
                end else if (cs_fall) begin
                    next_state.st = ST_IDLE;
                    next_state.do_drv = 1'b0;
                end
            end
            ST_OP: begin
                if (sk_rise) begin
                    next_state.op = {state.op[0], di_s};
                    next_state.cnt = state.cnt + 4'h1;
                    if (state.cnt == OP_LAST) begin
                        next_state.st = ST_ADDR;
                        next_state.cnt = '0;
                    end
                end
            end
            ST_ADDR: begin
                if (sk_rise) begin
                    next_state.sr = {state.sr[7:0], di_s};    // see [RULE_15]
                    next_state.cnt = state.cnt + 4'h1;
                    if (state.cnt == FIELD_LAST) begin
                        next_state.cnt = '0;
                        next_state.addr = {state.sr[6:0], di_s};
                        next_state.job = JOB_NONE;
                        next_state.st = ST_DONE;
                        case (state.op)
                            OP_READ: begin
                                next_state.st = ST_READ;        // see [RULE_18]
                                next_state.rd_cnt = '0;
                                next_state.do_drv = 1'b1;       // see [RULE_19]
                                next_state.do_val = 1'b0;       // see [RULE_17]
                            end
                            OP_WRITE: next_state.st = ST_DATA;  // see [RULE_18]
                            OP_ERASE: next_state.job = JOB_ERASE; // see [RULE_05]
                            default: begin
                                case (state.sr[7:6])
                                    SUB_UNLOCK: next_state.unlocked = 1'b1; // see [RULE_16]
                                    SUB_LOCK: next_state.unlocked = 1'b0;
                                    SUB_CLEAR: next_state.job = JOB_CLEAR;
                                    SUB_FILL: next_state.st = ST_DATA; // see [RULE_01]
                                    default: next_state.job = JOB_NONE;
                                endcase
                            end
                        endcase
                    end
                end
            end
            ST_DATA: begin
                if (sk_rise) begin
                    next_state.sr = {state.sr[7:0], di_s};
                    next_state.cnt = state.cnt + 4'h1;
                    if (state.cnt == DATA_LAST) begin
                        next_state.data = {state.sr[6:0], di_s};
                        next_state.job = (state.op == OP_WRITE) ? JOB_WRITE : JOB_FILL;
                        next_state.st = ST_DONE;
                    end
                end
            end
            ST_READ: begin
                if (sk_rise) begin
                    next_state.do_val = state.mem[state.addr][~state.rd_cnt]; // see [RULE_17]
                    next_state.rd_cnt = state.rd_cnt + 3'h1;
                    if (state.rd_cnt == 3'(DATA_LAST)) begin
                        next_state.addr = state.addr + 8'h1;
                    end
                end
            end
            ST_BUSY: begin
                next_state.do_drv = cs_s;    // see [RULE_09]
                next_state.do_val = 1'b0;
                if (tmr_done) begin
                    next_state.st = ST_READY;
                    next_state.do_val = 1'b1;
                    case (state.job)
                        JOB_WRITE: next_state.mem[state.addr] = state.data;
                        JOB_ERASE: next_state.mem[state.addr] = ERASED; // see [RULE_06]
                        JOB_FILL: begin
                            for (int i = 0; i < MEM_DEPTH; i++) begin
                                next_state.mem[i] = state.data; // see [RULE_02] [RULE_03]
                            end
                        end
                        JOB_CLEAR: begin
                            for (int i = 0; i < MEM_DEPTH; i++) begin
                                next_state.mem[i] = ERASED;
                            end
                        end
                        default: next_state.job = JOB_NONE;
                    endcase
                end
            end
            default: next_state.st = ST_DONE;
        endcase
        // Select fall ends any frame; busy ignores the serial lines
        if (cs_fall && (state.st != ST_BUSY) && (state.st != ST_READY)) begin
            next_state.do_drv = 1'b0;
            next_state.st = ST_IDLE;                 // see [RULE_20]
            if (tmr_start) begin
                next_state.st = ST_BUSY;             // see [RULE_04] [RULE_07] [RULE_09]
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
            state.st <= ST_IDLE;
            state.job <= JOB_NONE;
            state.mem <= {MEM_DEPTH{ERASED}};
        end else begin
            state <= next_state;
        end
    end

    assign iap_rdata = state.rdata;
    assign serial_out = state.do_val;
    assign serial_out_oe_n = !state.do_drv;

    property p_locked_no_cycle;
        @(posedge clk) disable iff (!rst_n)
        (state.st == ST_DONE && cs_fall && !state.unlocked) |=> (state.st == ST_IDLE);
    endproperty
    a_locked_no_cycle: assert property (p_locked_no_cycle) else $error("locked write began"); // see [RULE_04]

    property p_busy_do_low;
        @(posedge clk) disable iff (!rst_n)
        (state.st == ST_BUSY && cs_s && !tmr_done) |=> (!serial_out_oe_n && !serial_out);
    endproperty
    a_busy_do_low: assert property (p_busy_do_low) else $error("busy not shown low"); // see [RULE_09]

    property p_cycle_len;
        @(posedge clk) disable iff (!rst_n)
        $rose(tmr_busy) |-> tmr_busy[*8];
    endproperty
    a_cycle_len: assert property (p_cycle_len) else $error("write cycle too short"); // see [RULE_07]

    property p_busy_ignores;
        @(posedge clk) disable iff (!rst_n)
        (state.st == ST_BUSY && !tmr_done) |=> (state.st == ST_BUSY && $stable(state.addr));
    endproperty
    a_busy_ignores: assert property (p_busy_ignores) else $error("frame taken while busy"); // see [RULE_08]

    property p_partial_drop;
        @(posedge clk) disable iff (!rst_n)
        ((state.st == ST_OP || state.st == ST_ADDR || state.st == ST_DATA) && cs_fall)
            |=> (state.st == ST_IDLE) ##1 !tmr_busy;
    endproperty
    a_partial_drop: assert property (p_partial_drop) else $error("partial frame acted on"); // see [RULE_20]

    property p_fill_all;
        @(posedge clk) disable iff (!rst_n)
        (tmr_done && state.job == JOB_FILL)
            |=> (state.mem[0] == $past(state.data)) && (state.mem[MEM_DEPTH-1] == $past(state.data));
    endproperty
    a_fill_all: assert property (p_fill_all) else $error("fill-all incomplete"); // see [RULE_02]

    property p_erase_ones;
        @(posedge clk) disable iff (!rst_n)
        (tmr_done && state.job == JOB_ERASE) |=> (state.mem[state.addr] == ERASED);
    endproperty
    a_erase_ones: assert property (p_erase_ones) else $error("erase left zeros"); // see [RULE_06]

    property p_read_dummy;
        @(posedge clk) disable iff (!rst_n)
        (state.st == ST_ADDR && state.op == OP_READ && sk_rise && state.cnt == FIELD_LAST)
            |=> (!serial_out_oe_n && !serial_out && state.st == ST_READ);
    endproperty
    a_read_dummy: assert property (p_read_dummy) else $error("no dummy zero before read"); // see [RULE_17]

    property p_unlock;
        @(posedge clk) disable iff (!rst_n)
        (state.st == ST_ADDR && state.op == OP_EXT && sk_rise && state.cnt == FIELD_LAST
            && state.sr[7:6] == SUB_UNLOCK) |=> state.unlocked;
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock not taken"); // see [RULE_16]

    property p_reg_miss;
        @(posedge clk) disable iff (!rst_n)
        (!reg_hit) |=> (iap_rdata == 8'h00);
    endproperty
    a_reg_miss: assert property (p_reg_miss) else $error("register seen off 0x40"); // see [RULE_13]
endmodule

/* File: verilog/eesc_pkg.sv */
// Shared constants and types for the serial EEPROM command port.
// Assumes one 100 MHz system clock and the control register at 0x40.
package eesc_pkg;

    // Register placement and bit fields of the control register
    localparam logic [7:0] CTRL_ADDR = 8'h40;
    localparam int unsigned CS_BIT = 4;
    localparam int unsigned SK_BIT = 5;
    localparam int unsigned DI_BIT = 6;
    localparam int unsigned DO_BIT = 7;
    localparam logic [3:0] LOW_NIBBLE = 4'h0;

    // Instruction codes
    localparam logic [1:0] OP_EXT = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] SUB_LOCK = 2'h0;
    localparam logic [1:0] SUB_FILL = 2'h1;
    localparam logic [1:0] SUB_CLEAR = 2'h2;
    localparam logic [1:0] SUB_UNLOCK = 2'h3;

    // Field lengths and memory shape
    localparam int unsigned ADDR_BITS = 8;
    localparam int unsigned DATA_BITS = 8;
    localparam int unsigned MEM_DEPTH = 256;
    localparam logic [3:0] OP_LAST = 4'h1;
    localparam logic [3:0] FIELD_LAST = 4'h8;
    localparam logic [3:0] DATA_LAST = 4'h7;
    localparam logic [7:0] ERASED = 8'hff;

    // Internal write cycle timing
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned WRITE_TIME_US = 4000;
    localparam int unsigned WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;

    typedef enum logic [2:0] {
        ST_IDLE, ST_OP, ST_ADDR, ST_DATA, ST_READ, ST_DONE, ST_BUSY, ST_READY
    } eesc_state_t;

    typedef enum logic [2:0] {
        JOB_NONE, JOB_WRITE, JOB_ERASE, JOB_FILL, JOB_CLEAR
    } eesc_job_t;

endpackage

/* File: verilog/eesc_sync.sv */
// Two-stage synchroniser for a group of level signals.
// Assumes the inputs may change at any time relative to clk.
`timescale 1ns/1ps
module eesc_sync import eesc_pkg::*; #(
    parameter int unsigned W = 3
) (
    input wire logic clk,          // System clock
    input wire logic rst_n,        // Async reset, active low
    input wire logic [W-1:0] d,    // Asynchronous levels
    output logic [W-1:0] q         // Synchronised levels
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } eesc_sync_st_t;

    eesc_sync_st_t state;
    eesc_sync_st_t next_state;

    // First stage feeds only the second stage
    always_comb begin
        next_state = state;
        next_state.s1 = d;
        next_state.s2 = state.s1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign q = state.s2;
endmodule

/* File: verilog/eesc_write_timer.sv */
// Self-timed write cycle counter, independent of the serial clock.
// Assumes start is a one-cycle pulse given only while idle.
`timescale 1ns/1ps
module eesc_write_timer import eesc_pkg::*; #(
    parameter int unsigned CYCLES = WRITE_CYCLES
) (
    input wire logic clk,    // System clock
    input wire logic rst_n,  // Async reset, active low
    input wire logic start,  // Begin a write cycle
    output logic busy,       // Cycle in progress
    output logic done        // Last cycle of the write
);
    typedef struct packed {
        logic [31:0] cnt;
        logic busy;
    } eesc_tmr_st_t;

    eesc_tmr_st_t state;
    eesc_tmr_st_t next_state;

    if (CYCLES < 8) begin : g_chk
        $error("write cycle length must be at least 8 clocks");
    end

    // Count out the cycle and fall idle at its end
    always_comb begin
        next_state = state;
        if (!state.busy) begin
            if (start) begin
                next_state.busy = 1'b1;
                next_state.cnt = '0;
            end
        end else if (done) begin
            next_state.busy = 1'b0;
        end else begin
            next_state.cnt = state.cnt + 32'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign busy = state.busy;
    assign done = state.busy && (state.cnt == 32'(CYCLES - 1));
endmodule

/* File: verification/eesc_host.sv */
// Controller model: drives the control register through the indirect port.
// Assumes the port samples on rising clk; this model changes inputs at falling clk.
`timescale 1ns/1ps
module eesc_host import eesc_pkg::*; (
    input wire logic clk,               // System clock
    input wire logic [7:0] iap_rdata,   // Register read data
    output logic [7:0] indirect_pointer, // Pointer value
    output logic iap_wr,                // Write strobe
    output logic [7:0] iap_wdata        // Write data
);
    // Idle bus at time zero
    initial begin
        indirect_pointer = CTRL_ADDR;
        iap_wr = 1'b0;
        iap_wdata = 8'h00;
    end

    // One register write, then levels held so the synchroniser sees them
    task automatic put(input logic [7:0] ptr, input logic cs, input logic sk, input logic di);
        @(negedge clk);
        indirect_pointer = ptr;
        iap_wdata = {1'b0, di, sk, cs, LOW_NIBBLE};
        iap_wr = 1'b1;
        @(negedge clk);
        iap_wr = 1'b0;
        repeat (6) @(negedge clk);
    endtask

    // One serial bit; data-out is taken after the clock rise
    task automatic clk_bit(input logic b, output logic dout);
        put(CTRL_ADDR, 1'b1, 1'b0, b);
        put(CTRL_ADDR, 1'b1, 1'b1, b);
        dout = iap_rdata[DO_BIT];
        put(CTRL_ADDR, 1'b1, 1'b0, b);
    endtask

    // Shift n bits, most significant first
    task automatic send(input logic [19:0] v, input int n);
        logic d;
        for (int i = n - 1; i >= 0; i--) begin
            clk_bit(v[i], d);
        end
    endtask

    // Select high, start bit, opcode, 9-bit field, optional byte
    task automatic instr(input logic [1:0] op, input logic [8:0] fld,
                         input logic [7:0] dat, input logic wd);
        put(CTRL_ADDR, 1'b1, 1'b0, 1'b0);
        send({8'h00, 1'b1, op, fld}, 12);
        if (wd) begin
            send({12'h000, dat}, 8);
        end
    endtask

    // Select pulse, then poll data-out; nothing is sent while busy
    task automatic finish(output logic busy_seen, output logic ok);
        put(CTRL_ADDR, 1'b0, 1'b0, 1'b0);
        put(CTRL_ADDR, 1'b1, 1'b0, 1'b0);
        busy_seen = ~iap_rdata[DO_BIT];
        ok = 1'b0;
        for (int i = 0; i < 3000 && ok !== 1'b1; i++) begin
            @(negedge clk);
            ok = iap_rdata[DO_BIT];
        end
        put(CTRL_ADDR, 1'b0, 1'b0, 1'b0);
    endtask

    // Eight read-out bits, D7 first, one per clock rise; select stays high
    task automatic get(output logic [7:0] v);
        logic d;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b0, d);
            v[i] = d;
        end
    endtask

    // Read one byte: dummy level after A0, then eight bits
    task automatic read_byte(input logic [7:0] a, output logic [7:0] v, output logic dmy);
        instr(OP_READ, {1'b0, a}, 8'h00, 1'b0);
        dmy = iap_rdata[DO_BIT];
        get(v);
        put(CTRL_ADDR, 1'b0, 1'b0, 1'b0);
    endtask
endmodule

/* File: verification/eesc_port_tb.sv */
// Self-checking bench for the serial EEPROM command port.
// Assumes eesc_host as the controller and a short write cycle length.
`timescale 1ns/1ps
module eesc_port_tb import eesc_pkg::*;;

    localparam int unsigned WLEN = 1500;
    localparam int LIMIT = 90000;

    typedef struct {
        logic [1:0] op;
        logic [8:0] fld;
        logic [7:0] dat;
        logic [7:0] at;
        logic [7:0] exp;
    } eesc_row_t;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] indirect_pointer;
    logic iap_wr;
    logic [7:0] iap_wdata;
    logic [7:0] iap_rdata;
    logic serial_out;
    logic serial_out_oe_n;
    int err_total = 0;
    int check_count = 0;
    int cycles = 0;
    logic busy, ok, dmy, wd;
    logic [7:0] v;
    eesc_row_t rows[5];

    eesc_port #(.WRITE_LEN(WLEN)) dut (
        .clk(clk), .rst_n(rst_n), .indirect_pointer(indirect_pointer),
        .iap_wr(iap_wr), .iap_wdata(iap_wdata), .iap_rdata(iap_rdata),
        .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n));

    eesc_host h (
        .clk(clk), .iap_rdata(iap_rdata), .indirect_pointer(indirect_pointer),
        .iap_wr(iap_wr), .iap_wdata(iap_wdata));

    // Clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_total++;
            print_verdict();
        end
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("Checks %0d, errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Lock or unlock: no write cycle follows
    task automatic mode(input logic [1:0] sub);
        h.instr(OP_EXT, {sub, 7'h00}, 8'h00, 1'b0);
        h.put(CTRL_ADDR, 1'b0, 1'b0, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        h.read_byte(a, v, dmy);
        check("dummy", {7'h00, dmy}, 8'h00);
        check("byte", v, exp);
    endtask

    initial begin
        // Writes, erase, fill over old data, clear; each read back
        rows[0] = '{OP_WRITE, 9'h07f, 8'h55, 8'h7f, 8'h55};
        rows[1] = '{OP_WRITE, 9'h010, 8'ha5, 8'h10, 8'ha5};
        rows[2] = '{OP_ERASE, 9'h010, 8'h00, 8'h10, ERASED};
        rows[3] = '{OP_EXT, {SUB_FILL, 7'h7f}, 8'h3c, 8'h7f, 8'h3c};
        rows[4] = '{OP_EXT, {SUB_CLEAR, 7'h00}, 8'h00, 8'hc3, ERASED};
        repeat (16) @(negedge clk);
        check("rdata_rst", iap_rdata, 8'h00);
        check("oe_rst", {7'h00, serial_out_oe_n}, 8'h01);
        rst_n = 1'b1;
        // Register image: wrong pointer reads zero, bits 4..6 stored
        h.put(8'h41, 1'b0, 1'b1, 1'b1);
        check("rdata_ptr", iap_rdata, 8'h00);
        h.put(CTRL_ADDR, 1'b0, 1'b1, 1'b1);
        check("rdata_bits", iap_rdata, 8'he0);
        h.put(CTRL_ADDR, 1'b0, 1'b0, 1'b0);
        // Start-up: unlock, then a write; lock skipped
        mode(SUB_UNLOCK);
        foreach (rows[i]) begin
            // Only write and fill frames carry a data byte
            wd = (rows[i].op == OP_WRITE)
                || ((rows[i].op == OP_EXT) && (rows[i].fld[8:7] == SUB_FILL));
            h.instr(rows[i].op, rows[i].fld, rows[i].dat, wd);
            h.finish(busy, ok);
            check("busy", {7'h00, busy}, 8'h01);
            check("ready", {7'h00, ok}, 8'h01);
            rd(rows[i].at, rows[i].exp);
        end
        // Locked: write completes its frame but leaves memory alone
        mode(SUB_LOCK);
        h.instr(OP_WRITE, 9'h020, 8'h11, 1'b1);
        h.put(CTRL_ADDR, 1'b0, 1'b0, 1'b0);
        rd(8'h20, ERASED);
        // A frame sent during the write cycle is ignored
        mode(SUB_UNLOCK);
        h.instr(OP_WRITE, 9'h021, 8'h22, 1'b1);
        h.put(CTRL_ADDR, 1'b0, 1'b0, 1'b0);
        h.put(CTRL_ADDR, 1'b1, 1'b0, 1'b0);
        check("busy_mid", {7'h00, iap_rdata[DO_BIT]}, 8'h00);
        check("busy_pin", {6'h00, serial_out_oe_n, serial_out}, 8'h00);
        h.instr(OP_WRITE, 9'h022, 8'h33, 1'b1);
        h.finish(busy, ok);
        rd(8'h21, 8'h22);
        rd(8'h22, ERASED);
        // Two bytes in one read: address steps, no second dummy
        h.instr(OP_READ, 9'h021, 8'h00, 1'b0);
        h.get(v);
        check("seq0", v, 8'h22);
        h.get(v);
        check("seq1", v, ERASED);
        h.put(CTRL_ADDR, 1'b0, 1'b0, 1'b0);
        // Select dropped before the data byte discards the frame
        h.instr(OP_WRITE, 9'h030, 8'h00, 1'b0);
        h.put(CTRL_ADDR, 1'b0, 1'b0, 1'b0);
        h.put(CTRL_ADDR, 1'b1, 1'b0, 1'b0);
        check("no_cycle", {7'h00, serial_out_oe_n}, 8'h01);
        h.put(CTRL_ADDR, 1'b0, 1'b0, 1'b0);
        rd(8'h30, ERASED);
        // Reset in mid-run clears the outputs and the unlock
        @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        check("rdata_mid", iap_rdata, 8'h00);
        check("pin_mid", {6'h00, serial_out_oe_n, serial_out}, 8'h02);
        rst_n = 1'b1;
        h.instr(OP_WRITE, 9'h040, 8'h99, 1'b1);
        h.finish(busy, ok);
        check("busy_lock", {7'h00, busy}, 8'h00);
        rd(8'h40, ERASED);
        print_verdict();
    end
endmodule
